// ==== common/pdb_pkg.sv ====
// package for the pwm duty double-buffer block
// assumes one 250 MHz core clock and plain control ports, no register bus
// How it works
// [R01] duty is eight high bits from duty_high_byte, two low from control bits 5:4
// [R02] high time equals duty times clock period times prescale factor
// [R03] duty accepted anytime, copied to shadow only at period-limit match
// [R04] in pwm mode shadow is readable, software writes to it ignored
// [R05] two low bits held in own latch, loaded with shadow, glitch free
// [R06] pin cleared when shadow duty equals timer extended by two sub-cycle bits
// [R07] duty longer than period never clears the pin
// [R08] two-bit output config selects single, half, full forward, full reverse
// [R09] period timer prescale factors are 1, 4 and 16
// [R10] the shared second timer is the time base, common to units in pwm; here each pdb_pwm instantiates its own pdb_timebase
// [R11] on limit match timer clears and pin goes high unless duty is zero
package pdb_pkg;
	localparam int DUTY_W       = 10;
	localparam int TMR_W        = 8;
	localparam int CTL_LSB_HI   = 5;
	localparam int CTL_LSB_LO   = 4;
	localparam int CTL_CFG_HI   = 1;
	localparam int CTL_CFG_LO   = 0;
	localparam logic [7:0] CTL_RESET  = 8'h00;
	localparam logic [7:0] DUTY_RESET = 8'h00;
	localparam logic [1:0] PRE_DIV1   = 2'h0;
	localparam logic [1:0] PRE_DIV4   = 2'h1;
	localparam logic [1:0] PRE_DIV16  = 2'h2;

	typedef enum logic [1:0] {
		CFG_SINGLE, CFG_HALF, CFG_FULL_FWD, CFG_FULL_REV
	} pdb_cfg_type;

	// software-side write strobes with data
	typedef struct packed {
		logic       duty_we;
		logic [7:0] duty_high_byte;
		logic       ctl_we;
		logic [7:0] capture_pwm_control;
		logic       shadow_we;
		logic [7:0] shadow_wdata;
	} pdb_wr_type;
endpackage

// ==== design/pdb_timebase.sv ====
// period timer with prescaler, the second timer, instantiated once inside each pwm unit
// assumes limit and prescale select come from the same clock domain
`timescale 1ns/1ns
module pdb_timebase
	import pdb_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire logic             run,
	input  wire logic [1:0]       prescale_sel,
	input  wire logic [TMR_W-1:0] period_limit,
	output logic [TMR_W-1:0]      period_timer,
	output logic [1:0]            sub_count,
	output logic                  period_end
);
	logic [3:0] pre_cnt;
	logic [3:0] pre_max;
	logic       tick;

	// [R09] prescale 1, 4, 16
	always_comb begin
		unique case (prescale_sel)
			PRE_DIV1:  pre_max = 4'h0;
			PRE_DIV4:  pre_max = 4'h3;
			default:   pre_max = 4'hF;
		endcase
	end
	assign tick = (pre_cnt == pre_max);
	assign period_end = run && tick && (sub_count == 2'h3) && (period_timer == period_limit);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_cnt <= 4'h0;
		end else if (!run || tick) begin
			pre_cnt <= 4'h0;
		end else begin
			pre_cnt <= pre_cnt + 4'h1;
		end
	end

	// [R06] two sub-cycle bits below the timer, one step per prescaled tick
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sub_count <= 2'h0;
		end else if (!run) begin
			sub_count <= 2'h0;
		end else if (tick) begin
			sub_count <= sub_count + 2'h1;
		end
	end

	// [R11] timer clears on limit match
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			period_timer <= '0;
		end else if (!run || period_end) begin
			period_timer <= '0;
		end else if (tick && sub_count == 2'h3) begin
			period_timer <= period_timer + 8'h01;
		end
	end
endmodule // pdb_timebase

// ==== design/pdb_pwm.sv ====
// duty double buffer, compare and output steering for one pwm unit
// assumes software strobes are synchronous to core_clk
`timescale 1ns/1ns
module pdb_pwm
	import pdb_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire logic             pwm_enable,
	input  wire logic [1:0]       prescale_sel,
	input  wire logic [TMR_W-1:0] period_limit,
	input  wire pdb_wr_type       wr,
	output logic [7:0]            duty_shadow,
	output logic [1:0]            duty_low_latch,
	output logic [TMR_W-1:0]      period_timer_q,
	output logic                  pwm_output_pin,
	output logic [3:0]            bridge_out
);
	logic [7:0]        duty_high_byte;
	logic [7:0]        capture_pwm_control;
	logic [TMR_W-1:0]  period_timer;
	logic [1:0]        sub_count;
	logic              period_end;
	logic [DUTY_W-1:0] active_duty;
	logic              match;
	logic              pin;
	logic              pin_live;
	pdb_cfg_type       cfg;

	// next period's duty word, as software last wrote it
	function automatic logic [DUTY_W-1:0] duty_word(
		input logic [7:0] hi,
		input logic [7:0] ctl
	);
		return {hi, ctl[CTL_LSB_HI:CTL_LSB_LO]};
	endfunction

	// [R10] second timer as the time base
	pdb_timebase u_tb (
		.core_clk     (core_clk),
		.arst_n       (arst_n),
		.run          (pwm_enable),
		.prescale_sel (prescale_sel),
		.period_limit (period_limit),
		.period_timer (period_timer),
		.sub_count    (sub_count),
		.period_end   (period_end)
	);

	// [R03] duty writable at any time
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			duty_high_byte <= DUTY_RESET;
		end else if (wr.duty_we) begin
			duty_high_byte <= wr.duty_high_byte;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			capture_pwm_control <= CTL_RESET;
		end else if (wr.ctl_we) begin
			capture_pwm_control <= wr.capture_pwm_control;
		end
	end

	// [R01] [R03] [R04] shadow loads at period end only; writes ignored in pwm mode
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			duty_shadow <= DUTY_RESET;
		end else if (pwm_enable && period_end) begin
			duty_shadow <= duty_high_byte;
		end else if (!pwm_enable && wr.shadow_we) begin
			duty_shadow <= wr.shadow_wdata;
		end
	end

	// [R05] low bits latch loads with the shadow
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			duty_low_latch <= 2'h0;
		end else if (pwm_enable && period_end) begin
			duty_low_latch <= capture_pwm_control[CTL_LSB_HI:CTL_LSB_LO];
		end
	end

	assign active_duty = {duty_shadow, duty_low_latch};
	// [R06] [R07] compare extended timer; unreachable duty never clears
	assign match = ({period_timer, sub_count} == active_duty);
	// [R02] [R06] pin drops in the cycle the count reaches duty, not one cycle later
	assign pin_live = pin & ~match;
	assign cfg   = pdb_cfg_type'(capture_pwm_control[CTL_CFG_HI:CTL_CFG_LO]);

	// [R02] [R11] high from period start until duty match
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin <= 1'b0;
		end else if (!pwm_enable) begin
			pin <= 1'b0;
		end else if (period_end) begin
			pin <= (duty_word(duty_high_byte, capture_pwm_control) != 10'h000);
		end else if (match) begin
			pin <= 1'b0;
		end
	end

	// [R08] output arrangement; dead band not modelled
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwm_output_pin <= 1'b0;
			bridge_out     <= 4'h0;
		end else begin
			pwm_output_pin <= pin_live;
			unique case (cfg)
				CFG_SINGLE:   bridge_out <= {3'h0, pin_live};
				CFG_HALF:     bridge_out <= {2'h0, ~pin_live & pwm_enable, pin_live};
				CFG_FULL_FWD: bridge_out <= {pin_live, 2'h0, pwm_enable};
				CFG_FULL_REV: bridge_out <= {1'b0, pwm_enable, pin_live, 1'b0};
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			period_timer_q <= '0;
		end else begin
			period_timer_q <= period_timer;
		end
	end

	// period boundary while running, and the two-step fall of the pin
	sequence s_period_start;
		pwm_enable && period_end;
	endsequence
	sequence s_pin_falls;
		!pin ##1 !pwm_output_pin;
	endsequence

	// [R03] shadow held mid period
	a_shadow_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // [R03]
		pwm_enable && !period_end |=> $stable(duty_shadow))
		else $error("shadow changed mid period");

	// [R04] software write ignored
	a_shadow_ro: assert property (@(posedge core_clk) disable iff (!arst_n) // [R04]
		pwm_enable && wr.shadow_we && !period_end |=> $stable(duty_shadow))
		else $error("shadow write took");

	// [R05] latch tracks control
	a_latch_load: assert property (@(posedge core_clk) disable iff (!arst_n) // [R05]
		s_period_start |=> duty_low_latch == $past(capture_pwm_control[CTL_LSB_HI:CTL_LSB_LO]))
		else $error("latch miss");

	// [R05] latch held mid period
	a_latch_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // [R05]
		pwm_enable && !period_end |=> $stable(duty_low_latch))
		else $error("latch changed mid period");

	// [R01] shadow takes high byte
	a_shadow_load: assert property (@(posedge core_clk) disable iff (!arst_n) // [R01]
		s_period_start |=> duty_shadow == $past(duty_high_byte))
		else $error("shadow load wrong");

	// [R06] match clears pin
	a_match_clear: assert property (@(posedge core_clk) disable iff (!arst_n) // [R06]
		pwm_enable && match && !period_end |=> s_pin_falls)
		else $error("pin not cleared");

	// [R06] sub count restarts
	a_sub_wrap: assert property (@(posedge core_clk) disable iff (!arst_n) // [R06]
		s_period_start |=> sub_count == 2'h0)
		else $error("sub count not restarted");

	// [R03] end only at limit
	a_limit_end: assert property (@(posedge core_clk) disable iff (!arst_n) // [R03]
		period_end |-> period_timer == period_limit && sub_count == 2'h3)
		else $error("period end off limit");

	// [R11] period start drives pin high
	a_period_high: assert property (@(posedge core_clk) disable iff (!arst_n) // [R11]
		s_period_start ##0 (duty_word(duty_high_byte, capture_pwm_control) != 10'h000) |=> pin)
		else $error("pin not set");

	// [R11] zero duty stays low
	a_zero_duty: assert property (@(posedge core_clk) disable iff (!arst_n) // [R11]
		s_period_start ##0 (duty_word(duty_high_byte, capture_pwm_control) == 10'h000) |=> !pin)
		else $error("zero duty pin high");

	// [R07] no match keeps pin
	a_long_duty: assert property (@(posedge core_clk) disable iff (!arst_n) // [R07]
		pwm_enable && pin && !match && !period_end |=> pin)
		else $error("pin dropped early");

	// [R11] timer restarts after end
	a_timer_wrap: assert property (@(posedge core_clk) disable iff (!arst_n) // [R11]
		period_end |=> period_timer == 8'h00)
		else $error("timer not cleared");

	// [R10] stopped unit holds pin low
	a_idle_low: assert property (@(posedge core_clk) disable iff (!arst_n) // [R10]
		!pwm_enable |=> !pin)
		else $error("pin high while stopped");

	// [R10] stopped time base rests at zero
	a_timer_idle: assert property (@(posedge core_clk) disable iff (!arst_n) // [R10]
		!pwm_enable |=> period_timer == 8'h00 && sub_count == 2'h0)
		else $error("timer ran while stopped");

	// [R08] single mode mirrors pin
	a_single_out: assert property (@(posedge core_clk) disable iff (!arst_n) // [R08]
		cfg == CFG_SINGLE |=> bridge_out == {3'h0, $past(pin_live)})
		else $error("single output wrong");

	// [R08] half bridge pair
	a_half_pair: assert property (@(posedge core_clk) disable iff (!arst_n) // [R08]
		cfg == CFG_HALF |=> bridge_out == {2'h0, $past(~pin_live & pwm_enable), $past(pin_live)})
		else $error("half bridge wrong");

	// [R08] full bridge forward
	a_fwd_drive: assert property (@(posedge core_clk) disable iff (!arst_n) // [R08]
		cfg == CFG_FULL_FWD |=> bridge_out == {$past(pin_live), 2'h0, $past(pwm_enable)})
		else $error("forward bridge wrong");

	// [R08] full bridge reverse
	a_rev_drive: assert property (@(posedge core_clk) disable iff (!arst_n) // [R08]
		cfg == CFG_FULL_REV |=> bridge_out == {1'b0, $past(pwm_enable), $past(pin_live), 1'b0})
		else $error("reverse bridge wrong");

	// [R09] prescale 4 spaces sub steps
	a_prescale4: assert property (@(posedge core_clk) disable iff (!arst_n) // [R09]
		pwm_enable && prescale_sel == PRE_DIV4 && $changed(sub_count) ##1 pwm_enable && prescale_sel == PRE_DIV4
		|-> $stable(sub_count))
		else $error("prescale wrong");
endmodule // pdb_pwm

// ==== test/pdb_bench.sv ====
// bench for the pwm duty double buffer: high time per period, shadow and latch
// assumes pdb_pwm holds its own period timer and drives period_timer_q
`timescale 1ns/1ns
module pwm_duty_double_buffer_bench
	import pdb_pkg::*;
;
	logic        core_clk = 0, arst_n = 0, en = 0, pin;
	logic [1:0]  pre = 2'h0, lat;
	logic [7:0]  lim = 8'h03, sh, tq, prev_t = 8'h00, old;
	logic [3:0]  br;
	logic [9:0]  d;
	pdb_wr_type  wr = '0;
	logic [15:0] exp_q[$], hcnt = 16'h0;
	int          err_total = 0, comparisons = 0, seed = 32'hFD4BF4FF;
	event        bnd;

	always #2 core_clk = ~core_clk;

	pdb_pwm i_pdb_pwm (.core_clk(core_clk), .arst_n(arst_n), .pwm_enable(en), .prescale_sel(pre),
		.period_limit(lim), .wr(wr), .duty_shadow(sh), .duty_low_latch(lat), .period_timer_q(tq),
		.pwm_output_pin(pin), .bridge_out(br));

	task automatic chk_reg(input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (e !== g) begin
			err_total++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic chk_width(input logic [15:0] e, input logic [15:0] g);
		chk_reg(e, g);
	endtask

	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// high cycles counted between timer wraps
	always @(posedge core_clk) begin
		prev_t <= tq;
		hcnt <= (prev_t != 8'h00 && tq == 8'h00) ? {15'h0, pin} : hcnt + {15'h0, pin};
		if (prev_t != 8'h00 && tq == 8'h00) begin
			if (exp_q.size() > 0)
				chk_width(exp_q.pop_front(), hcnt);
			-> bnd;
		end
	end

	// limits only grow, so the timer never runs past a new limit
	task automatic run_case(input logic [1:0] p, input logic [7:0] l, input logic [9:0] dv, input logic [1:0] c);
		logic [15:0] per;
		per = ({8'h00, l} + 16'h1) * 16'h4;
		@(posedge core_clk);
		pre <= p;
		lim <= l;
		@bnd;
		@(negedge core_clk);
		old = sh;
		@(posedge core_clk);
		wr <= '{1'b1, dv[9:2], 1'b1, {2'h0, dv[1:0], 2'h0, c}, 1'b0, 8'h00};
		@(posedge core_clk);
		wr <= '0;
		@(negedge core_clk);
		chk_reg({8'h00, old}, {8'h00, sh});
		@bnd;
		@(negedge core_clk);
		chk_reg({8'h00, dv[9:2]}, {8'h00, sh});
		chk_reg({14'h0, dv[1:0]}, {14'h0, lat});
		if (c == CFG_HALF)
			chk_reg({15'h0, ~br[0]}, {15'h0, br[1]});
		exp_q.push_back(dv == 10'h0 ? 16'h0 : ((({6'h0, dv} < per) ? {6'h0, dv} : per) << (2 * p)));
		@bnd;
		$display("case done: prescale %0d duty %0d", p, dv);
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		en <= 1'b1;
		run_case(PRE_DIV1, 8'h03, 10'h005, CFG_SINGLE);
		run_case(PRE_DIV4, 8'h07, 10'h025, CFG_HALF);
		run_case(PRE_DIV16, 8'h07, 10'h003, CFG_FULL_FWD);
		run_case(PRE_DIV1, 8'h07, 10'h000, CFG_FULL_REV);
		run_case(PRE_DIV1, 8'h07, 10'h028, CFG_SINGLE);
		for (int i = 0; i < 3; i++) begin
			d = 10'($unsigned($random(seed)) % 30) + 10'h1;
			run_case(PRE_DIV1, 8'h09, d, 2'(i));
		end
		old = sh;
		@(posedge core_clk);
		wr <= '{1'b0, 8'h00, 1'b0, 8'h00, 1'b1, ~old};
		@(posedge core_clk);
		wr <= '0;
		@(negedge core_clk);
		chk_reg({8'h00, old}, {8'h00, sh});
		@(posedge core_clk);
		en <= 1'b0;
		wr <= '{1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 8'h5A};
		@(posedge core_clk);
		wr <= '0;
		repeat (2) @(negedge core_clk);
		chk_reg(16'h005A, {8'h00, sh});
		$display("case done: shadow write guard");
		finish_test();
	end

	// hang guard, far beyond the longest run
	initial begin
		#100000;
		err_total++;
		finish_test();
	end
endmodule // pwm_duty_double_buffer_bench
